// ---- design/serial_ch1_pkg.sv ----
// Purpose: Shared constants and types for the channel 1 serial control and framing block.
// Assumes: One 10 MHz clock, 32-bit Avalon-MM register access, word-aligned registers.
// Notes:   Register offsets are byte addresses derived from register indices.
`default_nettype none
package serial_ch1_pkg;
  localparam int          CLK_HZ          = 10_000_000;
  localparam int          BAUD_HZ         = 9_600;
  localparam logic [15:0] BIT_CYCLES      = 16'(CLK_HZ / BAUD_HZ);
  localparam logic [15:0] HALF_CYCLES     = 16'(CLK_HZ / BAUD_HZ / 2);
  localparam logic [4:0]  IDX_CTRL_A      = 5'h01;
  localparam logic [4:0]  IDX_CTRL_B      = 5'h02;
  localparam logic [4:0]  IDX_TX_DATA     = 5'h04;
  localparam logic [4:0]  IDX_RX_DATA     = 5'h05;
  localparam logic [4:0]  IDX_STATUS      = 5'h06;
  localparam logic [4:0]  IDX_IRQ_STAT    = 5'h07;
  localparam logic [4:0]  IDX_IRQ_MASK    = 5'h08;
  localparam logic [4:0]  IDX_CONTROL     = 5'h09;
  localparam logic [6:0]  OFF_CTRL_A      = {IDX_CTRL_A, 2'b00};
  localparam logic [6:0]  OFF_CTRL_B      = {IDX_CTRL_B, 2'b00};
  localparam logic [6:0]  OFF_TX_DATA     = {IDX_TX_DATA, 2'b00};
  localparam logic [6:0]  OFF_RX_DATA     = {IDX_RX_DATA, 2'b00};
  localparam logic [6:0]  OFF_STATUS      = {IDX_STATUS, 2'b00};
  localparam logic [6:0]  OFF_IRQ_STAT    = {IDX_IRQ_STAT, 2'b00};
  localparam logic [6:0]  OFF_IRQ_MASK    = {IDX_IRQ_MASK, 2'b00};
  localparam logic [6:0]  OFF_CONTROL     = {IDX_CONTROL, 2'b00};
  localparam int          A_WAKE          = 7;
  localparam int          A_RX_ON         = 6;
  localparam int          A_TX_ON         = 5;
  localparam int          A_CLK_OFF       = 4;
  localparam int          A_ADDR_ERR      = 3;
  localparam int          A_WIDTH         = 2;
  localparam int          A_PARITY        = 1;
  localparam int          A_STOP          = 0;
  localparam int          B_ADDR_TX       = 7;
  localparam int          B_MULTI         = 6;
  localparam int          B_ODD           = 4;
  localparam logic [7:0]  CTRL_A_RESET    = 8'h00;
  localparam logic [7:0]  CTRL_B_RESET    = 8'h07;
  localparam int          ST_RX_FULL      = 0;
  localparam int          ST_TX_EMPTY     = 1;
  localparam int          ST_OVERRUN      = 2;
  localparam int          ST_FRAMING      = 3;
  localparam int          ST_PARITY       = 4;
  localparam logic [31:0] UNMAPPED_DATA   = 32'h0000_0000;
  typedef struct packed {
    logic       width8;
    logic       parity_on;
    logic       stop2;
    logic       multi;
    logic       odd;
    logic       addr_bit;
  } frame_cfg_t;
  typedef struct packed {
    logic       done;
    logic [7:0] data;
    logic       addr_bit;
    logic       parity_bad;
    logic       stop_bad;
  } rx_result_t;
endpackage
`default_nettype wire

// ---- design/serial_bit_timer.sv ----
// Purpose: Bit-period timer shared by receiver and transmitter.
// Assumes: Restart reloads the count; a tick pulses when the count expires.
// Notes:   Reloads itself after each tick so a whole frame runs on one restart.
`default_nettype none
module serial_bit_timer
  import serial_ch1_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        run,
  input  wire logic        restart,
  input  wire logic [15:0] first_len,
  output logic             tick
);
  logic [15:0] cnt_q;
  always_ff @(posedge core_clk) begin
    if (rst || !run) begin
      cnt_q <= 16'h0000;
      tick  <= 1'b0;
    end else if (restart) begin
      cnt_q <= first_len - 16'h0001;
      tick  <= 1'b0;
    end else if (cnt_q == 16'h0000) begin
      cnt_q <= BIT_CYCLES - 16'h0001;
      tick  <= 1'b1;
    end else begin
      cnt_q <= cnt_q - 16'h0001;
      tick  <= 1'b0;
    end
  end
endmodule // serial_bit_timer
`default_nettype wire

// ---- design/serial_ch1_ctrl.sv ----
// Purpose: Channel 1 serial control, framing, receive filter and register file.
// Assumes: Avalon-MM slave with waitrequest; one answer cycle per access.
// Notes:   Baud generation is a fixed bit timer; clock source bits are stored only.
//
// Our own choice: register access over Avalon-MM.
`default_nettype none
// Summary of operation
// R1: Multi-node format with wake filter: only address-flagged characters touch receive and error flags.
// R2: Multi-node format without filter: every character updates receive and error flags.
// R3: Without multi-node format the wake filter bit is ignored.
// R4: Receiver enable starts reception; clearing aborts it and keeps flags.
// R5: Receiver enable cleared by reset and by the I/O halt state.
// R6: Transmitter enable starts sending; clearing aborts it and keeps empty flag.
// R7: Transmitter enable cleared by reset and by the I/O halt state.
// R8: Clock-pin off bit selects DMA end or channel serial clock on shared pin.
// R9: In multi-node format bit 3 reads the last received address flag.
// R10: Writing zero to bit 3 clears overrun, framing and parity faults.
// R11: Bit 3 has no defined reset value; nothing relies on it.
// R12: Format field picks data width, parity enable and stop count.
// R13: Frame is start, data, optional parity, stops; all eight formats legal.
// R14: Second control register resets clock selects high, others low.
// R15: Multi-node frame carries an address flag bit and never parity.
// R16: Parity sense bit picks even at zero, odd at one.
// R17: Parity covers data bits only; mismatch sets the parity fault.
module serial_ch1_ctrl
  import serial_ch1_pkg::*;
(
  input  wire logic        core_clk,
  input  wire logic        rst,
  input  wire logic        io_halt_state,
  input  wire logic [6:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  input  wire logic [3:0]  avs_byteenable,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  input  wire logic        rx_pin,
  output logic             tx_pin,
  input  wire logic        ch1_serial_clk_in,
  input  wire logic        dma_end_in,
  output logic             ch1_serial_clk_out,
  output logic             ch1_serial_clk_oe,
  output logic             dma_end_pin,
  output logic             dma_end_oe,
  output logic             ch1_clk_seen,
  output logic             irq
);
  typedef enum {RX_IDLE, RX_START, RX_BITS, RX_STOP} rx_state_t;
  typedef enum {TX_IDLE, TX_SHIFT} tx_state_t;
  logic [7:0]  ctrl_a_q;
  logic [7:0]  ctrl_b_q;
  logic [7:0]  tx_data_q;
  logic [7:0]  rx_data_q;
  logic        addr_seen_q;
  logic        rx_full_flag;
  logic        tx_empty_flag;
  logic        overrun_flag;
  logic        framing_fault;
  logic        parity_fault;
  logic [4:0]  irq_stat_q;
  logic [4:0]  irq_mask_q;
  logic        clk_drive_q;
  logic [2:0]  rx_sync_q;
  logic        rx_line_q;
  logic [2:0]  cki_sync_q;
  rx_state_t   rx_state_q;
  tx_state_t   tx_state_q;
  logic [3:0]  rx_cnt_q;
  logic [10:0] rx_shift_q;
  logic [3:0]  tx_cnt_q;
  logic [11:0] tx_shift_q;
  logic        rx_tick;
  logic        tx_tick;
  logic        rx_restart;
  logic        tx_restart;
  logic        rx_run;
  logic        tx_run;
  logic        wr_en;
  logic        rd_en;
  frame_cfg_t  cfg;
  rx_result_t  res;
  logic [3:0]  rx_len;
  logic        accept;
  logic [31:0] rd_mux;
  logic [4:0]  events;
  logic [7:0]  ctrl_a_rd;
  logic        tx_slot;
  assign cfg.width8    = ctrl_a_q[A_WIDTH];
  assign cfg.parity_on = ctrl_a_q[A_PARITY] && !ctrl_b_q[B_MULTI];
  assign cfg.stop2     = ctrl_a_q[A_STOP];
  assign cfg.multi     = ctrl_b_q[B_MULTI];
  assign cfg.odd       = ctrl_b_q[B_ODD];
  assign cfg.addr_bit  = ctrl_b_q[B_ADDR_TX];
  // Bus access decode: every request is answered on the cycle after it is seen.
  assign wr_en = avs_write && !avs_waitrequest && avs_byteenable[0];
  assign rd_en = avs_read && !avs_waitrequest;
  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_waitrequest <= 1'b1;
    end else if ((avs_read || avs_write) && avs_waitrequest) begin
      avs_waitrequest <= 1'b0;
    end else begin
      avs_waitrequest <= 1'b1;
    end
  end
  // R12 format field
  // R5 receiver forced off
  // R7 transmitter forced off
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_a_q <= CTRL_A_RESET;
    end else begin
      if (wr_en && avs_address == OFF_CTRL_A) begin
        ctrl_a_q <= avs_writedata[7:0];
      end
      if (io_halt_state) begin
        ctrl_a_q[A_RX_ON] <= 1'b0;
        ctrl_a_q[A_TX_ON] <= 1'b0;
      end
    end
  end
  // R14 second register reset
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ctrl_b_q <= CTRL_B_RESET;
    end else if (wr_en && avs_address == OFF_CTRL_B) begin
      ctrl_b_q <= avs_writedata[7:0];
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_mask_q  <= 5'h00;
      clk_drive_q <= 1'b0;
    end else if (wr_en && avs_address == OFF_IRQ_MASK) begin
      irq_mask_q <= avs_writedata[4:0];
    end else if (wr_en && avs_address == OFF_CONTROL) begin
      clk_drive_q <= avs_writedata[0];
    end
  end
  // Three-stage input synchronisers; a receive line change counts when stages two and three agree, clock seen needs both high.
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_sync_q  <= 3'b111;
      rx_line_q  <= 1'b1;
      cki_sync_q <= 3'b000;
    end else begin
      rx_sync_q  <= {rx_sync_q[1:0], rx_pin};
      cki_sync_q <= {cki_sync_q[1:0], ch1_serial_clk_in};
      if (rx_sync_q[2] == rx_sync_q[1]) begin
        rx_line_q <= rx_sync_q[1];
      end
    end
  end
  // R13 frame length
  // R15 address bit slot
  assign rx_len = 4'd7 + {3'b000, cfg.width8} + {3'b000, cfg.parity_on} + {3'b000, cfg.multi};
  assign rx_run = ctrl_a_q[A_RX_ON];
  assign rx_restart = rx_run && rx_state_q == RX_IDLE && !rx_line_q;
  serial_bit_timer u_rx_timer (
    .core_clk  (core_clk),
    .rst       (rst),
    .run       (rx_run),
    .restart   (rx_restart),
    .first_len (HALF_CYCLES),
    .tick      (rx_tick)
  );
  // R4 receiver abort
  always_ff @(posedge core_clk) begin
    if (rst || !rx_run) begin
      rx_state_q <= RX_IDLE;
      rx_cnt_q   <= 4'h0;
      rx_shift_q <= 11'h000;
    end else begin
      case (rx_state_q)
        RX_IDLE: begin
          if (rx_restart) begin
            rx_state_q <= RX_START;
          end
        end
        RX_START: begin
          if (rx_tick) begin
            rx_state_q <= rx_line_q ? RX_IDLE : RX_BITS;
            rx_cnt_q   <= 4'h0;
          end
        end
        RX_BITS: begin
          if (rx_tick) begin
            rx_shift_q[rx_cnt_q] <= rx_line_q;
            rx_cnt_q             <= rx_cnt_q + 4'h1;
            if (rx_cnt_q == rx_len - 4'h1) begin
              rx_state_q <= RX_STOP;
            end
          end
        end
        RX_STOP: begin
          if (rx_tick) begin
            rx_state_q <= RX_IDLE;
          end
        end
        default: rx_state_q <= RX_IDLE;
      endcase
    end
  end
  // R17 parity over data only
  // R16 parity sense
  always_comb begin
    res.done       = rx_run && rx_state_q == RX_STOP && rx_tick;
    res.data       = cfg.width8 ? rx_shift_q[7:0] : {1'b0, rx_shift_q[6:0]};
    res.addr_bit   = cfg.width8 ? rx_shift_q[8] : rx_shift_q[7];
    res.parity_bad = cfg.parity_on &&
                     ((^res.data ^ (cfg.width8 ? rx_shift_q[8] : rx_shift_q[7])) != cfg.odd);
    res.stop_bad   = !rx_line_q;
  end
  // R1 wake filter
  // R2 unfiltered update
  // R3 filter ignored
  assign accept = res.done && (!(cfg.multi && ctrl_a_q[A_WAKE]) || res.addr_bit);
  // Clears from software lose to a simultaneous hardware set.
  // R10 error clear
  always_ff @(posedge core_clk) begin
    if (rst) begin
      rx_full_flag  <= 1'b0;
      overrun_flag  <= 1'b0;
      framing_fault <= 1'b0;
      parity_fault  <= 1'b0;
      rx_data_q     <= 8'h00;
    end else begin
      if (wr_en && avs_address == OFF_CTRL_A && !avs_writedata[A_ADDR_ERR]) begin
        overrun_flag  <= 1'b0;
        framing_fault <= 1'b0;
        parity_fault  <= 1'b0;
      end
      if (rd_en && avs_address == OFF_RX_DATA) begin
        rx_full_flag <= 1'b0;
      end
      if (accept) begin
        rx_full_flag <= 1'b1;
        rx_data_q    <= res.data;
        if (rx_full_flag) begin
          overrun_flag <= 1'b1;
        end
        if (res.parity_bad) begin
          parity_fault <= 1'b1;
        end
        if (res.stop_bad) begin
          framing_fault <= 1'b1;
        end
      end
    end
  end
  // R9 last address flag
  // R11 no reset value needed
  always_ff @(posedge core_clk) begin
    if (accept || (res.done && cfg.multi)) begin
      addr_seen_q <= res.addr_bit;
    end
  end
  assign tx_run     = ctrl_a_q[A_TX_ON];
  assign tx_restart = tx_run && tx_state_q == TX_IDLE && !tx_empty_flag;
  assign tx_slot    = cfg.multi ? cfg.addr_bit :
                      (!cfg.parity_on || (^(cfg.width8 ? tx_data_q : {1'b0, tx_data_q[6:0]}) ^ cfg.odd));
  serial_bit_timer u_tx_timer (
    .core_clk  (core_clk),
    .rst       (rst),
    .run       (tx_run),
    .restart   (tx_restart),
    .first_len (BIT_CYCLES),
    .tick      (tx_tick)
  );
  // R6 transmitter abort
  // R13 transmit framing
  always_ff @(posedge core_clk) begin
    if (rst || !tx_run) begin
      tx_state_q <= TX_IDLE;
      tx_cnt_q   <= 4'h0;
      tx_shift_q <= 12'hfff;
      tx_pin     <= 1'b1;
    end else begin
      case (tx_state_q)
        TX_IDLE: begin
          tx_pin <= 1'b1;
          if (tx_restart) begin
            tx_state_q <= TX_SHIFT;
            tx_pin     <= 1'b0;
            tx_cnt_q   <= rx_len + {3'b000, cfg.stop2} + 4'h2;
            if (cfg.width8) begin
              tx_shift_q <= {2'b11, tx_slot, tx_data_q, 1'b0};
            end else begin
              tx_shift_q <= {3'b111, tx_slot, tx_data_q[6:0], 1'b0};
            end
          end
        end
        TX_SHIFT: begin
          if (tx_tick) begin
            tx_shift_q <= {1'b1, tx_shift_q[11:1]};
            tx_pin     <= tx_shift_q[1];
            tx_cnt_q   <= tx_cnt_q - 4'h1;
            if (tx_cnt_q == 4'h1) begin
              tx_state_q <= TX_IDLE;
              tx_pin     <= 1'b1;
            end
          end
        end
        default: tx_state_q <= TX_IDLE;
      endcase
    end
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      tx_empty_flag <= 1'b1;
      tx_data_q     <= 8'h00;
    end else if (wr_en && avs_address == OFF_TX_DATA) begin
      tx_data_q     <= avs_writedata[7:0];
      tx_empty_flag <= 1'b0;
    end else if (tx_restart) begin
      tx_empty_flag <= 1'b1;
    end
  end
  // R8 shared pin select
  always_ff @(posedge core_clk) begin
    if (rst) begin
      ch1_serial_clk_out <= 1'b0;
      ch1_serial_clk_oe  <= 1'b0;
      dma_end_pin        <= 1'b0;
      dma_end_oe         <= 1'b0;
      ch1_clk_seen       <= 1'b0;
    end else begin
      ch1_serial_clk_out <= tx_tick;
      ch1_serial_clk_oe  <= !ctrl_a_q[A_CLK_OFF] && clk_drive_q;
      dma_end_pin        <= dma_end_in;
      dma_end_oe         <= ctrl_a_q[A_CLK_OFF];
      ch1_clk_seen       <= !ctrl_a_q[A_CLK_OFF] && cki_sync_q[2] && cki_sync_q[1];
    end
  end
  assign events = {parity_fault, framing_fault, overrun_flag, tx_empty_flag, accept};
  always_ff @(posedge core_clk) begin
    if (rst) begin
      irq_stat_q <= 5'h00;
      irq        <= 1'b0;
    end else begin
      irq_stat_q <= (wr_en && avs_address == OFF_IRQ_STAT) ?
                    ((irq_stat_q & ~avs_writedata[4:0]) | events) : (irq_stat_q | events);
      irq        <= |(irq_stat_q & irq_mask_q);
    end
  end
  assign ctrl_a_rd = {ctrl_a_q[7:4], cfg.multi ? addr_seen_q : 1'b0, ctrl_a_q[2:0]};
  always_comb begin
    case (avs_address)
      OFF_CTRL_A:   rd_mux = {24'h000000, ctrl_a_rd};
      OFF_CTRL_B:   rd_mux = {24'h000000, ctrl_b_q};
      OFF_TX_DATA:  rd_mux = {24'h000000, tx_data_q};
      OFF_RX_DATA:  rd_mux = {24'h000000, rx_data_q};
      OFF_STATUS:   rd_mux = {27'h0000000, parity_fault, framing_fault, overrun_flag, tx_empty_flag, rx_full_flag};
      OFF_IRQ_STAT: rd_mux = {27'h0000000, irq_stat_q};
      OFF_IRQ_MASK: rd_mux = {27'h0000000, irq_mask_q};
      OFF_CONTROL:  rd_mux = {31'h00000000, clk_drive_q};
      default:      rd_mux = UNMAPPED_DATA;
    endcase
  end
  always_ff @(posedge core_clk) begin
    if (rst) begin
      avs_readdata <= 32'h0000_0000;
    end else if (avs_read && avs_waitrequest) begin
      avs_readdata <= rd_mux;
    end
  end
endmodule // serial_ch1_ctrl
`default_nettype wire

// ---- sim/serial_ch1_sva.sv ----
// Purpose: Port checks for the channel 1 serial control block.
// Assumes: One clock; reset values are read before any write.
// Notes:   Seen flags record which control registers were written.
`default_nettype none
module serial_ch1_sva
  import serial_ch1_pkg::*;
(
  input wire logic        core_clk,
  input wire logic        rst,
  input wire logic        io_halt_state,
  input wire logic [6:0]  avs_address,
  input wire logic        avs_read,
  input wire logic        avs_write,
  input wire logic [31:0] avs_writedata,
  input wire logic [3:0]  avs_byteenable,
  input wire logic [31:0] avs_readdata,
  input wire logic        avs_waitrequest,
  input wire logic        tx_pin,
  input wire logic        ch1_serial_clk_oe,
  input wire logic        dma_end_oe
);
  timeunit 1ns;
  timeprecision 1ns;
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (rst);
  logic wr_a, wr_b, rd_a, rd_b;
  logic a_seen_q, b_seen_q;
  assign wr_a = !avs_waitrequest && avs_write && avs_byteenable[0] && avs_address == OFF_CTRL_A;
  assign wr_b = !avs_waitrequest && avs_write && avs_byteenable[0] && avs_address == OFF_CTRL_B;
  assign rd_a = !avs_waitrequest && avs_read && avs_address == OFF_CTRL_A;
  assign rd_b = !avs_waitrequest && avs_read && avs_address == OFF_CTRL_B;
  always_ff @(posedge core_clk) begin
    a_seen_q <= !rst && (a_seen_q || wr_a);
    b_seen_q <= !rst && (b_seen_q || wr_b);
  end
  property p_dma_oe;
    wr_a && avs_writedata[A_CLK_OFF] |-> ##[1:3] dma_end_oe;
  endproperty
  a_dma_oe: assert property (p_dma_oe) else $error("pin not given to dma end");
  property p_pin_excl;
    ch1_serial_clk_oe |-> !dma_end_oe;
  endproperty
  a_pin_excl: assert property (p_pin_excl) else $error("both pin drivers enabled");
  property p_halt_rx;
    io_halt_state [*3] ##0 rd_a |-> !avs_readdata[A_RX_ON];
  endproperty
  a_halt_rx: assert property (p_halt_rx) else $error("receiver enable survived halt");
  property p_halt_tx;
    rd_a && io_halt_state && $past(io_halt_state) && $past(io_halt_state, 2) |-> !avs_readdata[A_TX_ON];
  endproperty
  a_halt_tx: assert property (p_halt_tx) else $error("transmitter enable survived halt");
  property p_halt_line;
    io_halt_state [*6] |-> tx_pin;
  endproperty
  a_halt_line: assert property (p_halt_line) else $error("line not idle under halt");
  property p_a_reset;
    rd_a && !a_seen_q |-> (avs_readdata & 32'hf7) == 32'h0;
  endproperty
  a_a_reset: assert property (p_a_reset) else $error("control a reset value wrong");
  property p_b_reset;
    rd_b && !b_seen_q |-> avs_readdata[6:0] == 7'h07;
  endproperty
  a_b_reset: assert property (p_b_reset) else $error("control b reset value wrong");
  property p_tx_reset;
    $past(rst) |-> tx_pin;
  endproperty
  a_tx_reset: assert property (p_tx_reset) else $error("line not idle after reset");
  c_halt_read: cover property (io_halt_state && rd_a);
  c_dma: cover property ($rose(dma_end_oe));
  c_b_write: cover property (wr_b);
endmodule // serial_ch1_sva
bind serial_ch1_ctrl serial_ch1_sva chk_u (
  .core_clk(core_clk), .rst(rst), .io_halt_state(io_halt_state), .avs_address(avs_address),
  .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata),
  .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest),
  .tx_pin(tx_pin), .ch1_serial_clk_oe(ch1_serial_clk_oe), .dma_end_oe(dma_end_oe)
);
`default_nettype wire

// ---- sim/serial_node.sv ----
// Purpose: Remote node on the shared serial line of channel 1.
// Assumes: Line idles high; a bit lasts BIT_CYCLES clocks, least significant first.
// Notes:   Tasks are called just after a rising clock edge.
`default_nettype none
module serial_node
  import serial_ch1_pkg::*;
(
  input  wire logic core_clk,
  output logic      line_out,
  input  wire logic line_in
);
  timeunit 1ns;
  timeprecision 1ns;
  initial line_out = 1'b1;
  task automatic send_frame(input logic [11:0] p, input int n, input int s);
    line_out <= 1'b0;
    repeat (BIT_CYCLES) @(posedge core_clk);
    for (int i = 0; i < n + s; i++) begin
      line_out <= (i < n) ? p[i] : 1'b1;
      repeat (BIT_CYCLES) @(posedge core_clk);
    end
  endtask
  task automatic catch_frame(input int n, output logic [11:0] f);
    f = 12'h000;
    for (int k = 0; k < 40000 && line_in !== 1'b0; k++)
      @(posedge core_clk);
    repeat (HALF_CYCLES) @(posedge core_clk);
    for (int i = 0; i <= n; i++) begin
      repeat (BIT_CYCLES) @(posedge core_clk);
      f[i] = line_in;
    end
  endtask
endmodule // serial_node
`default_nettype wire

// ---- sim/tb.sv ----
// Purpose: Self-checking bench for the channel 1 serial control block.
// Assumes: 10 MHz clock; a serial node model stands on the line.
// Notes:   At most three characters per case keep the run short at 9600 baud.
`default_nettype none
module tb
  import serial_ch1_pkg::*;
  ;
  timeunit 1ns;
  timeprecision 1ns;
  logic        core_clk;
  logic        rst = 1'b1;
  logic        io_halt_state = 1'b0;
  logic [6:0]  avs_address = 7'h00;
  logic        avs_read = 1'b0;
  logic        avs_write = 1'b0;
  logic [31:0] avs_writedata = 32'h0;
  logic [31:0] avs_readdata;
  logic        avs_waitrequest;
  logic        rx_pin, tx_pin, clk_in, clk_out, clk_oe, dma_oe, dma_pin, clk_seen, irq;
  logic        clk_ext = 1'b0;
  logic        dma_in = 1'b0;
  int          bad_count = 0;
  int          n_checks = 0;
  assign clk_in = clk_oe ? clk_out : clk_ext;
  serial_ch1_ctrl dut_u (
    .core_clk(core_clk), .rst(rst), .io_halt_state(io_halt_state), .avs_address(avs_address),
    .avs_read(avs_read), .avs_write(avs_write), .avs_writedata(avs_writedata), .avs_byteenable(4'hf),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest), .rx_pin(rx_pin), .tx_pin(tx_pin),
    .ch1_serial_clk_in(clk_in), .dma_end_in(dma_in), .ch1_serial_clk_out(clk_out), .ch1_serial_clk_oe(clk_oe),
    .dma_end_pin(dma_pin), .dma_end_oe(dma_oe), .ch1_clk_seen(clk_seen), .irq(irq)
  );
  serial_node node_u (.core_clk(core_clk), .line_out(rx_pin), .line_in(tx_pin));
  initial begin
    core_clk = 1'b0;
    forever #50 core_clk = ~core_clk;
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [6:0] a, input logic [31:0] d, output logic [31:0] q);
    avs_address <= a;
    avs_writedata <= d;
    avs_write <= w;
    avs_read <= !w;
    @(posedge core_clk);
    while (avs_waitrequest !== 1'b0)
      @(posedge core_clk);
    q = avs_readdata;
    avs_write <= 1'b0;
    avs_read <= 1'b0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [6:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [6:0] a, input logic [31:0] m, input logic [31:0] e, input string s);
    logic [31:0] q;
    bus(1'b0, a, 32'h0, q);
    chk(q & m, e, s);
  endtask
  task automatic t_reset;
    rc(OFF_CTRL_A, 32'hffff_fff7, 32'h0, "ctrl a reset");
    rc(OFF_CTRL_B, 32'hffff_ff7f, 32'h07, "ctrl b reset");
    rc(7'h7c, 32'hffff_ffff, 32'h0, "unmapped read");
    chk(32'(tx_pin), 32'h1, "idle line");
    $display("test reset done");
  endtask
  task automatic t_halt;
    wr(OFF_CTRL_A, 32'h60);
    rc(OFF_CTRL_A, 32'h60, 32'h60, "enables set");
    io_halt_state <= 1'b1;
    repeat (3) @(posedge core_clk);
    rc(OFF_CTRL_A, 32'h60, 32'h0, "halt clears enables");
    io_halt_state <= 1'b0;
    $display("test halt done");
  endtask
  task automatic t_pin;
    wr(OFF_CTRL_A, 32'h10);
    repeat (3) @(posedge core_clk);
    chk(32'({dma_oe, clk_oe}), 32'h2, "dma end owns pin");
    dma_in <= 1'b1;
    repeat (2) @(posedge core_clk);
    chk(32'(dma_pin), 32'h1, "dma end carried");
    wr(OFF_CTRL_A, 32'h00);
    wr(OFF_CONTROL, 32'h01);
    repeat (3) @(posedge core_clk);
    chk(32'({dma_oe, clk_oe}), 32'h1, "clock owns pin");
    wr(OFF_CONTROL, 32'h00);
    clk_ext <= 1'b1;
    repeat (8) @(posedge core_clk);
    chk(32'(clk_seen), 32'h1, "clock input seen");
    $display("test pin done");
  endtask
  task automatic t_tx;
    logic [11:0] f;
    wr(OFF_CTRL_A, 32'h20);
    wr(OFF_TX_DATA, 32'h55);
    node_u.catch_frame(7, f);
    // Seven data bits then a high stop; an eighth data bit would read 0 here.
    chk(32'(f[7:0]), 32'hd5, "7-bit frame sent");
    $display("test tx done");
  endtask
  task automatic t_rx;
    wr(OFF_IRQ_MASK, 32'h10);
    wr(OFF_CTRL_A, 32'hc7);
    node_u.send_frame(12'h0a5, 9, 2);
    rc(OFF_STATUS, 32'h1d, 32'h01, "even parity ok");
    rc(OFF_RX_DATA, 32'hffff_ffff, 32'ha5, "rx data");
    wr(OFF_CTRL_B, 32'h17);
    node_u.send_frame(12'h0a5, 9, 2);
    rc(OFF_STATUS, 32'h1c, 32'h10, "odd parity fault");
    chk(32'(irq), 32'h1, "irq raised");
    wr(OFF_IRQ_MASK, 32'h0);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0, "irq masked");
    wr(OFF_IRQ_MASK, 32'h10);
    wr(OFF_CTRL_A, 32'h47);
    rc(OFF_STATUS, 32'h1c, 32'h0, "faults cleared");
    wr(OFF_IRQ_STAT, 32'h10);
    repeat (2) @(posedge core_clk);
    chk(32'(irq), 32'h0, "irq cleared");
    rc(OFF_RX_DATA, 32'hffff_ffff, 32'ha5, "second rx data");
    $display("test rx done");
  endtask
  task automatic t_multi;
    wr(OFF_CTRL_B, 32'h47);
    wr(OFF_CTRL_A, 32'hc4);
    node_u.send_frame(12'h03c, 9, 1);
    rc(OFF_STATUS, 32'h1d, 32'h0, "plain char ignored");
    node_u.send_frame(12'h181, 9, 1);
    rc(OFF_STATUS, 32'h1d, 32'h01, "address char taken");
    rc(OFF_CTRL_A, 32'hff, 32'hcc, "address flag read");
    rc(OFF_RX_DATA, 32'hffff_ffff, 32'h81, "address char data");
    wr(OFF_CTRL_A, 32'h44);
    node_u.send_frame(12'h03c, 9, 1);
    rc(OFF_STATUS, 32'h1d, 32'h01, "unfiltered char taken");
    rc(OFF_CTRL_A, 32'hff, 32'h44, "address flag cleared");
    rc(OFF_RX_DATA, 32'hffff_ffff, 32'h3c, "unfiltered char data");
    $display("test multi done");
  endtask
  task automatic give_verdict;
    $display("checks %0d mismatches %0d", n_checks, bad_count);
    if (bad_count == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    t_reset();
    t_halt();
    t_pin();
    t_tx();
    t_rx();
    t_multi();
    give_verdict();
  end
  // Sized for six characters at 9600 baud plus register traffic.
  initial begin
    repeat (90000) @(posedge core_clk);
    bad_count++;
    $display("MISMATCH %0t watchdog expired", $time);
    give_verdict();
  end
endmodule // tb
`default_nettype wire
